// ### spd_select_code_decoder.sv
/*
  First-byte decoder of the serial link: start and stop detection, select byte
  shift and acknowledge, protect and page commands, protect flags, page select
  and a flip-flop model of the memory array.
  Assumes the bus pins and straps are asynchronous and are synchronised here;
  the open-drain data pin is resolved outside from sda_o and sda_oe_o.
*/
`timescale 1ns/100ps

module spd_select_code_decoder (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_strap_zero_i,
  input  wire logic       addr_strap_one_i,
  input  wire logic       addr_strap_two_i,
  input  wire logic       high_voltage_level_i,
  input  wire logic       factory_init_i,
  input  wire logic       mem_we_i,
  input  wire logic [7:0] mem_addr_i,
  input  wire logic [7:0] mem_wdata_i,
  output logic [7:0]      mem_rdata_o,
  output logic            mem_wr_refused_o,
  output logic            memory_select_o,
  output logic            sensor_select_o,
  output logic            read_dir_o,
  output logic            memory_page_o,
  output logic [3:0]      block_protect_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_byte_valid_o,
  output logic [1:0]      rx_byte_index_o
);

  typedef struct packed {
    logic                       scl_m;
    logic                       scl_s;
    logic                       scl_p;
    logic                       sda_m;
    logic                       sda_s;
    logic                       sda_p;
    logic [2:0]                 strap_m;
    logic [2:0]                 strap_s;
    logic                       hv_m;
    logic                       hv_s;
    spd_select_pkg::state_t     state;
    spd_select_pkg::target_t    target;
    logic [3:0]                 bit_cnt;
    logic [7:0]                 shreg;
    logic                       ack_drv;
    logic                       read_dir;
    logic                       page;
    logic [3:0]                 prot;
    logic [7:0]                 rx_byte;
    logic                       rx_valid;
    logic [1:0]                 rx_idx;
    logic                       wr_refused;
    logic [7:0]                 rdata;
    logic [511:0][7:0]          mem;
  } dec_state_t;

  dec_state_t q;
  dec_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  function automatic logic is_block_code(input logic [2:0] code);
    is_block_code = (code == spd_select_pkg::CODE_BLOCK0) ||
                    (code == spd_select_pkg::CODE_BLOCK1) ||
                    (code == spd_select_pkg::CODE_BLOCK2) ||
                    (code == spd_select_pkg::CODE_BLOCK3);
  endfunction

  // The block codes are not a binary block number, so they are mapped here.
  function automatic logic [1:0] block_of_code(input logic [2:0] code);
    unique case (code)
      spd_select_pkg::CODE_BLOCK0: block_of_code = 2'h0; // see RULE13
      spd_select_pkg::CODE_BLOCK1: block_of_code = 2'h1; // see RULE13
      spd_select_pkg::CODE_BLOCK2: block_of_code = 2'h2; // see RULE13
      default:                     block_of_code = 2'h3; // see RULE13
    endcase
  endfunction

  // Only the second synchroniser stage and its delayed copy feed edge logic.
  assign scl_rise  = q.scl_s & ~q.scl_p;
  assign scl_fall  = ~q.scl_s & q.scl_p;
  assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  always_comb
  begin
    d            = q;
    d.scl_m      = scl_i;
    d.scl_s      = q.scl_m;
    d.scl_p      = q.scl_s;
    d.sda_m      = sda_i;
    d.sda_s      = q.sda_m;
    d.sda_p      = q.sda_s;
    d.strap_m    = {addr_strap_two_i, addr_strap_one_i, addr_strap_zero_i}; // see RULE4
    d.strap_s    = q.strap_m;
    d.hv_m       = high_voltage_level_i; // see RULE21
    d.hv_s       = q.hv_m;
    d.rx_valid   = 1'b0;
    d.wr_refused = 1'b0;

    unique case (q.state)
      spd_select_pkg::ST_IDLE,
      spd_select_pkg::ST_STANDBY:
      begin
        d.ack_drv = 1'b0; // see RULE8
      end
      spd_select_pkg::ST_SHIFT:
      begin
        if (scl_rise)
        begin
          d.shreg   = {q.shreg[6:0], q.sda_s}; // see RULE18
          d.bit_cnt = q.bit_cnt + 4'h1;
        end
        if (scl_fall && q.bit_cnt == spd_select_pkg::BIT_ACK_SLOT)
        begin
          d.state    = spd_select_pkg::ST_ACK;
          d.read_dir = q.shreg[0]; // see RULE6
          d.ack_drv  = 1'b0;
          d.target   = spd_select_pkg::TGT_NONE;
          if (q.shreg[7:4] == spd_select_pkg::ID_MEMORY && q.shreg[3:1] == q.strap_s) // see RULE2
          begin
            d.target  = spd_select_pkg::TGT_MEMORY; // see RULE4
            d.ack_drv = 1'b1; // see RULE7
          end
          else if (q.shreg[7:4] == spd_select_pkg::ID_SENSOR && q.shreg[3:1] == q.strap_s) // see RULE1
          begin
            d.target  = spd_select_pkg::TGT_SENSOR; // see RULE4
            d.ack_drv = 1'b1; // see RULE7
          end
          else if (q.shreg[7:4] == spd_select_pkg::ID_COMMAND) // see RULE1
          begin
            // The logical address is not compared for commands. See RULE5.
            d.target = spd_select_pkg::TGT_COMMAND;
            if (!q.shreg[0])
            begin
              if (q.shreg[3:1] == spd_select_pkg::CODE_CLEAR_ALL)
              begin
                if (q.hv_s) // see RULE3
                begin
                  d.prot    = spd_select_pkg::PROT_CLEARED; // see RULE14
                  d.ack_drv = 1'b1;
                end
              end
              else if (q.shreg[3:1] == spd_select_pkg::CODE_PAGE0)
              begin
                d.page    = 1'b0; // see RULE16
                d.ack_drv = 1'b1;
              end
              else if (q.shreg[3:1] == spd_select_pkg::CODE_PAGE1)
              begin
                d.page    = 1'b1; // see RULE16
                d.ack_drv = 1'b1;
              end
              else if (is_block_code(q.shreg[3:1]) && q.hv_s) // see RULE3
              begin
                d.prot[block_of_code(q.shreg[3:1])] = 1'b1; // see RULE13
                d.ack_drv                          = 1'b1;
              end
            end
            else if (is_block_code(q.shreg[3:1]))
            begin
              d.ack_drv = ~q.prot[block_of_code(q.shreg[3:1])]; // see RULE15
            end
            else if (q.shreg[3:1] == spd_select_pkg::CODE_PAGE0)
            begin
              d.ack_drv = ~q.page; // see RULE17
            end
            // Every other command code is reserved: no acknowledge and no change. See RULE20.
          end
        end
      end
      spd_select_pkg::ST_ACK:
      begin
        if (scl_fall)
        begin
          d.ack_drv = 1'b0;
          d.bit_cnt = 4'h0;
          d.rx_idx  = 2'h0;
          if (q.ack_drv && (q.target == spd_select_pkg::TGT_MEMORY ||
                            q.target == spd_select_pkg::TGT_SENSOR))
          begin
            d.state = spd_select_pkg::ST_MATCHED;
          end
          else
          begin
            // Commands end at their own acknowledge; a mismatch just lets go. See RULE8.
            d.state  = spd_select_pkg::ST_STANDBY;
            d.target = spd_select_pkg::TGT_NONE;
          end
        end
      end
      spd_select_pkg::ST_MATCHED:
      begin
        if (scl_rise)
        begin
          if (q.bit_cnt == spd_select_pkg::BIT_ACK_SLOT)
          begin
            d.bit_cnt = 4'h0;
          end
          else
          begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            d.shreg   = {q.shreg[6:0], q.sda_s}; // see RULE18
          end
          if (q.bit_cnt == spd_select_pkg::BIT_LAST_DATA)
          begin
            // Byte 0 is the pointer, then the sensor's high and low bytes. See RULE19.
            d.rx_byte  = {q.shreg[6:0], q.sda_s};
            d.rx_valid = 1'b1;
          end
        end
        if (q.rx_valid && q.rx_idx != spd_select_pkg::BYTE_IDX_MAX)
        begin
          d.rx_idx = q.rx_idx + 2'h1;
        end
      end
      default:
      begin
        d.state = spd_select_pkg::ST_IDLE;
      end
    endcase

    if (bus_start)
    begin
      d.state   = spd_select_pkg::ST_SHIFT;
      d.bit_cnt = 4'h0;
      d.ack_drv = 1'b0;
      d.target  = spd_select_pkg::TGT_NONE;
    end
    else if (bus_stop)
    begin
      d.state   = spd_select_pkg::ST_IDLE;
      d.ack_drv = 1'b0;
      d.target  = spd_select_pkg::TGT_NONE;
    end

    // Writes into a protected block of the current page are refused.
    if (mem_we_i)
    begin
      if (q.prot[{q.page, mem_addr_i[7]}]) // see RULE11
      begin
        d.wr_refused = 1'b1;
      end
      else
      begin
        d.mem[{q.page, mem_addr_i}] = mem_wdata_i; // see RULE16
      end
    end
    d.rdata = q.mem[{q.page, mem_addr_i}]; // see RULE16

    // Power-on reset clears the link state but keeps the nonvolatile contents. See RULE9.
    if (rst_i)
    begin
      d         = '0;
      d.mem     = q.mem;  // see RULE12
      d.prot    = q.prot; // see RULE12
      d.page    = spd_select_pkg::PAGE_RESET; // see RULE21
      d.state   = spd_select_pkg::ST_IDLE;
      d.target  = spd_select_pkg::TGT_NONE;
      d.scl_m   = 1'b1;
      d.scl_s   = 1'b1;
      d.scl_p   = 1'b1;
      d.sda_m   = 1'b1;
      d.sda_s   = 1'b1;
      d.sda_p   = 1'b1;
    end

    // The delivered state comes after reset, so a pulse that overlaps reset still lands.
    if (factory_init_i)
    begin
      d.mem  = {spd_select_pkg::MEM_BYTES{spd_select_pkg::ERASED_BYTE}}; // see RULE10
      d.prot = spd_select_pkg::PROT_CLEARED;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    q <= d;
  end

  // The pin is open drain: it only ever pulls low, and the enable carries the data.
  assign sda_o            = 1'b0;
  assign sda_oe_o         = q.ack_drv; // see RULE7
  assign mem_rdata_o      = q.rdata;
  assign mem_wr_refused_o = q.wr_refused;
  assign memory_select_o  = (q.state == spd_select_pkg::ST_MATCHED) &&
                            (q.target == spd_select_pkg::TGT_MEMORY);
  assign sensor_select_o  = (q.state == spd_select_pkg::ST_MATCHED) &&
                            (q.target == spd_select_pkg::TGT_SENSOR);
  assign read_dir_o       = q.read_dir;
  assign memory_page_o    = q.page;
  assign block_protect_o  = q.prot;
  assign rx_byte_o        = q.rx_byte;
  assign rx_byte_valid_o  = q.rx_valid;
  assign rx_byte_index_o  = q.rx_idx;

endmodule // spd_select_code_decoder

// ### spd_select_pkg.sv
/*
  Constants and types shared by the select code decoder of a combined
  presence-detect memory and temperature sensor.
  Assumes a single 40 MHz clock and a synchronous, active-high reset.
*/
// Notes on behaviour
// RULE1 - Identifier 0110b selects protect and page commands; 0011b selects the sensor.
// RULE2 - Identifier 1010b in the upper nibble selects the memory array.
// RULE3 - Protect set or clear is honoured only while the high voltage strap flag is present.
// RULE4 - Three straps form the logical address; memory and sensor bytes must match it.
// RULE5 - Protect and page commands ignore the logical address on every device.
// RULE6 - Lowest bit of the first byte is direction: 1 read, 0 write.
// RULE7 - A matching first byte is acknowledged by pulling data low in the ninth bit.
// RULE8 - A mismatching first byte releases the bus and waits for the next start.
// RULE9 - Reset occurs at power-on; the master waits for the initialisation delay.
// RULE10 - The memory array model starts with every byte reading 0xFF.
// RULE11 - Four blocks: halves 0x00-0x7F and 0x80-0xFF of page 0 and page 1.
// RULE12 - Block protect flags survive power cycles.
// RULE13 - Write codes 001, 100, 101, 000 protect blocks 0, 1, 2, 3.
// RULE14 - Write code 011 clears all four protect flags when high voltage is present.
// RULE15 - Read with the block codes queries protection, at any strap level.
// RULE16 - Write codes 110 and 111 select page 0 and page 1 for later accesses.
// RULE17 - Read code 110 acknowledges for page 0 and withholds it for page 1.
// RULE18 - Every byte is sent most significant bit first.
// RULE19 - Sensor data transfers are two bytes, more significant byte first, after the pointer.
// RULE20 - Reserved command encodings are not acknowledged and change nothing.
// RULE21 - Page returns to 0 at power-on; high voltage arrives as one input flag.
package spd_select_pkg;

  localparam logic [3:0] ID_MEMORY      = 4'hA;
  localparam logic [3:0] ID_COMMAND     = 4'h6;
  localparam logic [3:0] ID_SENSOR      = 4'h3;

  localparam logic [2:0] CODE_BLOCK0    = 3'h1;
  localparam logic [2:0] CODE_BLOCK1    = 3'h4;
  localparam logic [2:0] CODE_BLOCK2    = 3'h5;
  localparam logic [2:0] CODE_BLOCK3    = 3'h0;
  localparam logic [2:0] CODE_CLEAR_ALL = 3'h3;
  localparam logic [2:0] CODE_PAGE0     = 3'h6;
  localparam logic [2:0] CODE_PAGE1     = 3'h7;

  localparam logic [3:0] BIT_LAST_DATA  = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT   = 4'h8;
  localparam logic [1:0] BYTE_IDX_MAX   = 2'h3;

  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam logic [3:0] PROT_CLEARED   = 4'h0;
  localparam logic       PAGE_RESET     = 1'h0;
  localparam int         MEM_BYTES      = 512;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_ACK,
    ST_MATCHED,
    ST_STANDBY
  } state_t;

  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_MEMORY,
    TGT_SENSOR,
    TGT_COMMAND
  } target_t;

endpackage

// ### spd_select_checker_assertions.sv
/*
  Port checks for the select code decoder.
  Assumes one clock and a synchronous reset; bound at the foot of this file.
*/
`timescale 1ns/100ps

module spd_select_checker (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       high_voltage_level_i,
  input wire logic       factory_init_i,
  input wire logic       mem_we_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic       sda_oe_o,
  input wire logic [7:0] mem_rdata_o,
  input wire logic       mem_wr_refused_o,
  input wire logic       memory_select_o,
  input wire logic       sensor_select_o,
  input wire logic       memory_page_o,
  input wire logic [3:0] block_protect_o,
  input wire logic       rx_byte_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic hit;
  logic refuse_q;
  assign hit = block_protect_o[{memory_page_o, mem_addr_i[7]}];
  always_ff @(posedge ref_clk_i) refuse_q <= mem_we_i && hit;
  sequence open_wr_s;
    mem_we_i && !hit;
  endsequence
  sequence held_s;
    $stable(mem_addr_i) && $stable(memory_page_o);
  endsequence
  reset_idle_a: assert property (
    $fell(rst_i) |-> !sda_oe_o && !memory_page_o && !memory_select_o && !sensor_select_o)
    else $error("not idle after reset");
  one_target_a: assert property (!(memory_select_o && sensor_select_o))
    else $error("two targets selected");
  ack_slot_a: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("ack raised with clock high");
  hv_guard_a: assert property (
    (!high_voltage_level_i && !factory_init_i)[*8] |=> $stable(block_protect_o))
    else $error("flags moved without high voltage");
  page_ack_a: assert property (
    $changed(memory_page_o) && !$past(rst_i) |-> ##[0:3] sda_oe_o)
    else $error("page moved without ack");
  rx_match_a: assert property (rx_byte_valid_o |-> memory_select_o || sensor_select_o)
    else $error("byte reported while deselected");
  refuse_a: assert property (mem_wr_refused_o == refuse_q)
    else $error("refusal wrong");
  store_a: assert property (
    open_wr_s ##1 held_s |=> mem_rdata_o == $past(mem_wdata_i, 2))
    else $error("write not stored");
  factory_a: assert property (factory_init_i |=> block_protect_o == 4'h0)
    else $error("flags not cleared");
endmodule // spd_select_checker

bind spd_select_code_decoder spd_select_checker checker_i (.*);

// ### spd_bus_master_model.sv
/*
  Behavioural bus master driving the serial clock and data lines.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/100ps

module spd_bus_master_model (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  int half = 8;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Data moves only while the clock is low, so no false start or stop appears.
  task automatic start();
    tick(2);
    sda_o = 1'b1;
    tick(half);
    scl_o = 1'b1;
    tick(half);
    sda_o = 1'b0;
    tick(half);
    scl_o = 1'b0;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      tick(2);
      sda_o = v[i];
      tick(half);
      scl_o = 1'b1;
      tick(half);
      scl_o = 1'b0;
    end
    tick(2);
    sda_o = 1'b1;
    tick(half);
    scl_o = 1'b1;
    tick(half / 2);
    ack = !sda_i;
    tick(half / 2);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_o = 1'b0;
    tick(half);
    scl_o = 1'b1;
    tick(half);
    sda_o = 1'b1;
    tick(half);
  endtask
endmodule // spd_bus_master_model

// ### spd_select_code_decoder_tb.sv
/*
  Self-checking bench: random and swept first bytes, array writes, sensor bytes, reset.
  Assumes the bus master model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps

module spd_select_code_decoder_tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  strap = 3'h0;
  logic        hv = 1'b0;
  logic        factory = 1'b1;
  logic        we = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [3:0]  prot_m = 4'h0;
  logic        page_m = 1'b0;
  logic [7:0]  rdata, rxb, b, mem_m [512];
  logic [3:0]  prot;
  logic [1:0]  rxi;
  logic [31:0] r;
  logic        scl, sda_m, sda_dev, sda_oe, refused, msel, ssel, rdir, page, ack, rxv;
  logic [1:0]  rxi_seen = 2'h0;
  int          rx_count = 0;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire         sda_w = sda_m & (sda_oe ? sda_dev : 1'b1);

  always #12.5 ref_clk_i = ~ref_clk_i;

  // The index moves on the cycle after the pulse, so it is caught while the pulse stands.
  always @(negedge ref_clk_i)
  begin
    if (rxv)
    begin
      rxi_seen <= rxi;
      rx_count <= rx_count + 1;
    end
  end

  spd_bus_master_model spd_bus_master_model_i (.ref_clk_i(ref_clk_i), .sda_i(sda_w),
    .scl_o(scl), .sda_o(sda_m));
  spd_select_code_decoder spd_select_code_decoder_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dev), .sda_oe_o(sda_oe),
    .addr_strap_zero_i(strap[0]), .addr_strap_one_i(strap[1]), .addr_strap_two_i(strap[2]),
    .high_voltage_level_i(hv), .factory_init_i(factory), .mem_we_i(we), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .mem_rdata_o(rdata), .mem_wr_refused_o(refused),
    .memory_select_o(msel), .sensor_select_o(ssel), .read_dir_o(rdir), .memory_page_o(page),
    .block_protect_o(prot), .rx_byte_o(rxb), .rx_byte_valid_o(rxv), .rx_byte_index_o(rxi));

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The block codes are scrambled on purpose, hence a table and not a binary field.
  function automatic int blk_of(input logic [2:0] c);
    case (c)
      3'h1: return 0;
      3'h4: return 1;
      3'h5: return 2;
      3'h0: return 3;
      default: return -1;
    endcase
  endfunction
  function automatic logic exp_ack(input logic [7:0] v);
    if (v[7:4] == 4'hA || v[7:4] == 4'h3)
      return v[3:1] == strap;
    if (v[7:4] != 4'h6)
      return 1'b0;
    if (blk_of(v[3:1]) >= 0)
      return v[0] ? !prot_m[blk_of(v[3:1])] : hv;
    if (v[3:1] == 3'h3)
      return !v[0] && hv;
    if (v[3:1] == 3'h6)
      return !v[0] || !page_m;
    return v[3:1] == 3'h7 && !v[0];
  endfunction
  task automatic cmd(input logic [7:0] v);
    logic e;
    e = exp_ack(v);
    spd_bus_master_model_i.start();
    spd_bus_master_model_i.send(v, ack);
    check("ack", 8'(ack), 8'(e));
    // The select outputs follow the synchronised end of the acknowledge slot.
    repeat (4) @(negedge ref_clk_i);
    check("memory select", 8'(msel), 8'(e && v[7:4] == 4'hA));
    check("sensor select", 8'(ssel), 8'(e && v[7:4] == 4'h3));
    if (e)
      check("direction", 8'(rdir), 8'(v[0]));
    spd_bus_master_model_i.stop();
    if (e && v[7:4] == 4'h6 && !v[0])
    begin
      if (blk_of(v[3:1]) >= 0)
        prot_m[blk_of(v[3:1])] = 1'b1;
      if (v[3:1] == 3'h3)
        prot_m = 4'h0;
      if (v[3:2] == 2'h3)
        page_m = v[1];
    end
    check("flags", 8'(prot), 8'(prot_m));
    check("page", 8'(page), 8'(page_m));
  endtask
  task automatic mem_op(input logic [7:0] a, input logic [7:0] d);
    logic p;
    p = prot_m[{page_m, a[7]}];
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge ref_clk_i);
    we = 1'b0;
    check("refused", 8'(refused), 8'(p));
    if (!p)
      mem_m[{page_m, a}] = d;
    @(negedge ref_clk_i);
    check("read data", rdata, mem_m[{page_m, a}]);
  endtask

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(32'h90653489));
    foreach (mem_m[i])
      mem_m[i] = 8'hFF;
    @(negedge ref_clk_i);
    factory = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      addr = 8'($urandom);
      repeat (2) @(negedge ref_clk_i);
      check("erased byte", rdata, 8'hFF);
    end
    $display("test erased done");
    for (int i = 0; i < 40; i++)
    begin
      r = $urandom;
      strap = r[2:0];
      hv = r[3];
      b = r[15:8];
      if (r[4])
        b[7:4] = r[5] ? 4'hA : 4'h3;
      if (r[6])
        b[3:1] = strap;
      cmd(b);
    end
    $display("test random select done");
    for (int p = 0; p < 3; p++)
    begin
      hv = p != 0;
      strap = 3'($urandom);
      for (int c = 0; c < 16; c++)
        cmd({4'h6, 4'(c)});
    end
    $display("test command sweep done");
    for (int i = 0; i < 32; i++)
    begin
      if (i == 16)
        cmd(8'h6C);
      @(negedge ref_clk_i);
      mem_op(8'($urandom), 8'($urandom));
    end
    $display("test array done");
    strap = 3'($urandom);
    spd_bus_master_model_i.half = 20;
    spd_bus_master_model_i.start();
    spd_bus_master_model_i.send({4'h3, strap, 1'b0}, ack);
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      spd_bus_master_model_i.send(b, ack);
      check("sensor byte", rxb, b);
      check("byte index", 8'(rxi_seen), 8'(i));
      check("byte pulses", 8'(rx_count), 8'(i + 1));
    end
    spd_bus_master_model_i.stop();
    $display("test sensor done");
    cmd(8'h6E);
    rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    page_m = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check("page after reset", 8'(page), 8'(page_m));
    check("flags after reset", 8'(prot), 8'(prot_m));
    cmd({4'hA, strap, 1'b1});
    factory = 1'b1;
    @(negedge ref_clk_i);
    factory = 1'b0;
    prot_m = 4'h0;
    repeat (2) @(negedge ref_clk_i);
    check("flags after init", 8'(prot), 8'(prot_m));
    check("byte after init", rdata, 8'hFF);
    $display("test reset done");
    stop_test();
  end
endmodule // spd_select_code_decoder_tb
